// ===== hw/mtrc_core.sv
// Transmit request sequencing, transmit command and transmit interrupt enables
`timescale 1ns/1ns
// Behaviour
// [R1] Enable register writes act on the very next event, even mid-frame.
// [R2] Enable bit 6 interrupts on carrier loss after preamble, attachment port only.
// [R3] Enable bit 7 interrupts on every signal quality error.
// [R4] Enable bit 8 interrupts on each successful transmission.
// [R5] Enable bit 9 interrupts on a late collision.
// [R6] Enable bit A interrupts on a babble condition.
// [R7] Enable bit B interrupts on any collision.
// [R8] Enable bit F interrupts after sixteen attempts on one frame.
// [R9] Buffer enable bit 8 interrupts when requested transmit space frees.
// [R10] Buffer enable bit 9 interrupts on transmit underrun.
// [R11] Buffer enable bit C interrupts on collision counter wrap.
// [R12] Host clears serial transmit enable before changing port selection bits.
// [R13] Host writes the command and a full request before every frame.
// [R14] Short frames pad to 64 with FCS, or 60 without FCS counted.
// [R15] FCS suppressed with padding on: lengths below 60 go out as runts.
// [R16] Both set: below 64 goes out as runt; below 3 never sent.
// [R17] Request order: command write, length write, then bus status read.
// [R18] Transmit command reads back its last written value.
// [R19] Command bits 7:6 pick preamble start after 5, 381, 1021 or all bytes.
// [R20] Command bit 8 discards all frame data held in the transmit buffer.
// [R21] Command bit 9 stops retries after a collision.
// [R22] Command bit C omits the 32-bit frame check value.
// [R23] Invalid length discards the command and sets request error bit 7.
// [R24] Ready-now bit 8 sets once buffer space covers the requested length.
// [R25] Bytes written for the frame are counted against the start threshold.
module mtrc_core (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic data_wr,
  input wire logic [10:0] buf_free_bytes,
  input wire logic aui_active,
  input wire logic ev_carrier_loss,
  input wire logic ev_sqe,
  input wire logic ev_tx_ok,
  input wire logic ev_late_collision,
  input wire logic ev_babble,
  input wire logic ev_collision,
  input wire logic ev_underrun,
  output logic tx_irq,
  output logic tx_start,
  output logic [10:0] tx_wire_len,
  output logic tx_fcs_append,
  output logic tx_retry_stop,
  output logic tx_discard,
  output logic serial_tx_en,
  output logic [1:0] port_select,
  output logic alt_backoff
);
  logic [15:0] tx_event_irq_enable_q, tx_event_irq_enable_d;
  logic [15:0] buffer_irq_enable_q, buffer_irq_enable_d;
  logic [15:0] line_control_q, line_control_d;
  logic [15:0] transmit_command_q, transmit_command_d;
  logic [15:0] pend_cmd_q, pend_cmd_d;
  logic [10:0] req_len_q, req_len_d;
  logic [10:0] byte_cnt_q, byte_cnt_d;
  logic [10:0] wire_len_q, wire_len_d;
  logic [9:0] collision_counter_q, collision_counter_d;
  logic [4:0] attempts_q, attempts_d;
  logic req_err_q, req_err_d;
  logic ready_now_q, ready_now_d;
  logic start_q, start_d;
  logic fcs_q, fcs_d;
  logic stop_q, stop_d;
  logic discard_q, discard_d;
  logic irq_q, irq_d;
  logic [15:0] rdata_q, rdata_d;
  mtrc_pkg::mtrc_req_e state_q, state_d;

  // Register address decode, shared by writes and reads
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // Bytes on the wire for a length under the given FCS choice; the pad bit is not an input
  function automatic logic [10:0] wire_bytes(input logic [10:0] len,
                                             input logic fcs_off);
    logic [10:0] body;
    body = (len < mtrc_pkg::PAD_TARGET) ? mtrc_pkg::PAD_TARGET : len;
    if (fcs_off) begin
      wire_bytes = len; // Runts go out unpadded [R15] [R16]
    end else begin
      wire_bytes = body + mtrc_pkg::FCS_BYTES; // 60 body plus FCS is 64 [R14] [R22]
    end
  endfunction

  // Length check: zero, oversize, or below three with both bits set
  function automatic logic bad_len(input logic [10:0] len, input logic [15:0] cmd);
    bad_len = (len == 11'h000) || (len > mtrc_pkg::MAX_FRAME) ||
              (cmd[mtrc_pkg::FCS_SUPPRESS] && cmd[mtrc_pkg::PAD_DISABLE] &&
               (len < mtrc_pkg::MIN_SENDABLE)); // [R16]
  endfunction

  logic wr_cmd, wr_len, rd_stat, frame_end, col_wrap, space_ok, thr_hit;
  logic [10:0] thr;
  logic [15:0] cmd_w;

  // Per-frame start threshold and shared decode terms
  always_comb begin
    wr_cmd = reg_wr && hit(reg_addr, mtrc_pkg::OFS_TRANSMIT_COMMAND);
    wr_len = reg_wr && hit(reg_addr, mtrc_pkg::OFS_TRANSMIT_FRAME_LENGTH);
    rd_stat = reg_rd && hit(reg_addr, mtrc_pkg::OFS_BUS_STATUS);
    cmd_w = reg_wdata & mtrc_pkg::TRANSMIT_COMMAND_MASK;
    space_ok = (buf_free_bytes >= req_len_q);
    col_wrap = ev_collision && (collision_counter_q == 10'h3FF);
    unique case (transmit_command_q[mtrc_pkg::START_SEL_LSB +: 2]) // [R19]
      2'b00: thr = mtrc_pkg::START_AFTER_5;
      2'b01: thr = mtrc_pkg::START_AFTER_381;
      2'b10: thr = mtrc_pkg::START_AFTER_1021;
      2'b11: thr = req_len_q;
    endcase
    thr_hit = (byte_cnt_q >= thr) || (byte_cnt_q >= req_len_q); // [R25]
    frame_end = ev_tx_ok || ev_late_collision || ev_babble || ev_underrun ||
                stop_q;
  end

  // Registers, request sequence, frame fill and events
  always_comb begin
    tx_event_irq_enable_d = tx_event_irq_enable_q;
    buffer_irq_enable_d = buffer_irq_enable_q;
    line_control_d = line_control_q;
    transmit_command_d = transmit_command_q;
    pend_cmd_d = pend_cmd_q;
    req_len_d = req_len_q;
    byte_cnt_d = byte_cnt_q;
    wire_len_d = wire_len_q;
    collision_counter_d = collision_counter_q;
    attempts_d = attempts_q;
    req_err_d = req_err_q;
    ready_now_d = ready_now_q;
    start_d = start_q;
    fcs_d = fcs_q;
    stop_d = 1'b0;
    discard_d = 1'b0;
    state_d = state_q;
    rdata_d = 16'h0000;
    // Configuration writes land at once and gate the next event [R1]
    if (reg_wr && hit(reg_addr, mtrc_pkg::OFS_TX_EVENT_IRQ_ENABLE)) begin
      tx_event_irq_enable_d = reg_wdata & mtrc_pkg::TX_EVENT_IRQ_MASK; // [R1]
    end
    if (reg_wr && hit(reg_addr, mtrc_pkg::OFS_BUFFER_IRQ_ENABLE)) begin
      buffer_irq_enable_d = reg_wdata & mtrc_pkg::BUFFER_IRQ_MASK; // [R1]
    end
    if (reg_wr && hit(reg_addr, mtrc_pkg::OFS_LINE_CONTROL)) begin
      line_control_d = reg_wdata & mtrc_pkg::LINE_CONTROL_MASK;
    end
    // Status read clears the request error; a new error in the same cycle wins
    if (rd_stat) begin
      req_err_d = 1'b0;
    end
    // Collision counter free-runs and wraps
    if (ev_collision) begin
      collision_counter_d = collision_counter_q + 10'h001;
    end
    // Request sequence
    unique case (state_q)
      mtrc_pkg::MTRC_IDLE: begin
        if (wr_cmd) begin
          pend_cmd_d = cmd_w;
          state_d = mtrc_pkg::MTRC_CMD_DONE; // [R17]
        end
      end
      mtrc_pkg::MTRC_CMD_DONE: begin
        if (wr_cmd) begin
          pend_cmd_d = cmd_w;
        end else if (wr_len) begin
          req_len_d = reg_wdata[10:0];
          if (bad_len(reg_wdata[10:0], pend_cmd_q) || (reg_wdata[15:11] != 5'h00))
          begin
            req_err_d = 1'b1; // Command dropped [R23]
            state_d = mtrc_pkg::MTRC_IDLE;
          end else begin
            transmit_command_d = pend_cmd_q;
            state_d = mtrc_pkg::MTRC_LEN_DONE;
          end
        end
      end
      mtrc_pkg::MTRC_LEN_DONE: begin
        if (wr_cmd) begin
          pend_cmd_d = cmd_w;
          state_d = mtrc_pkg::MTRC_CMD_DONE;
        end else if (rd_stat) begin
          fcs_d = ~transmit_command_q[mtrc_pkg::FCS_SUPPRESS]; // [R22]
          wire_len_d = wire_bytes(req_len_q, transmit_command_q[mtrc_pkg::FCS_SUPPRESS]);
          byte_cnt_d = 11'h000;
          attempts_d = 5'h00;
          state_d = space_ok ? mtrc_pkg::MTRC_FILL : mtrc_pkg::MTRC_WAIT_SPACE;
        end
      end
      mtrc_pkg::MTRC_WAIT_SPACE: begin
        if (space_ok) begin
          state_d = mtrc_pkg::MTRC_FILL;
        end
      end
      mtrc_pkg::MTRC_FILL: begin
        if (data_wr && (byte_cnt_q < req_len_q)) begin
          byte_cnt_d = byte_cnt_q + 11'h001; // [R25]
        end
        if (thr_hit) begin
          start_d = 1'b1; // [R19]
        end
        if (ev_collision && start_q) begin
          attempts_d = attempts_q + 5'h01;
          // Give up after one try or on the sixteenth [R21] [R8]
          if (transmit_command_q[mtrc_pkg::SINGLE_ATTEMPT] ||
              (attempts_q + 5'h01 == mtrc_pkg::MAX_ATTEMPTS)) begin
            stop_d = 1'b1; // [R21]
          end
        end
        if (frame_end) begin
          start_d = 1'b0;
          ready_now_d = 1'b0;
          state_d = mtrc_pkg::MTRC_IDLE;
        end
      end
      default: state_d = mtrc_pkg::MTRC_IDLE;
    endcase
    // Ready-now follows space for a committed request [R24]
    if ((state_d == mtrc_pkg::MTRC_FILL) && (state_q != mtrc_pkg::MTRC_FILL)) begin
      ready_now_d = 1'b1; // [R24]
    end
    // Forced discard flushes buffered frame data and any pending frame [R20]
    if (wr_cmd && cmd_w[mtrc_pkg::FORCE_DISCARD]) begin
      discard_d = 1'b1; // [R20]
      start_d = 1'b0;
      ready_now_d = 1'b0;
      byte_cnt_d = 11'h000;
      pend_cmd_d = cmd_w;
      state_d = mtrc_pkg::MTRC_CMD_DONE;
    end
    // Any command write is held for read-back [R18]
    if (wr_cmd) begin
      transmit_command_d = cmd_w; // [R18]
    end
    // Read data stands in the cycle after the strobe
    if (reg_rd) begin
      if (hit(reg_addr, mtrc_pkg::OFS_TX_EVENT_IRQ_ENABLE)) begin
        rdata_d = tx_event_irq_enable_q;
      end else if (hit(reg_addr, mtrc_pkg::OFS_BUFFER_IRQ_ENABLE)) begin
        rdata_d = buffer_irq_enable_q;
      end else if (hit(reg_addr, mtrc_pkg::OFS_LINE_CONTROL)) begin
        rdata_d = line_control_q;
      end else if (hit(reg_addr, mtrc_pkg::OFS_COLLISION_COUNTER)) begin
        rdata_d = {6'h00, collision_counter_q};
      end else if (rd_stat) begin
        rdata_d[mtrc_pkg::TX_REQUEST_ERROR] = req_err_q; // [R23]
        rdata_d[mtrc_pkg::TX_SPACE_READY_NOW] = ready_now_q; // [R24]
      end else if (hit(reg_addr, mtrc_pkg::OFS_TRANSMIT_COMMAND)) begin
        rdata_d = transmit_command_q; // [R18]
      end
    end
  end

  // Enabled events merge into one interrupt request pulse, live enables [R1]
  always_comb begin
    irq_d = 1'b0;
    if (tx_event_irq_enable_q[mtrc_pkg::CARRIER_LOSS_IRQ_EN] && ev_carrier_loss &&
        aui_active) begin
      irq_d = 1'b1; // [R2]
    end
    if (tx_event_irq_enable_q[mtrc_pkg::SIGNAL_QUALITY_ERR_IRQ_EN] && ev_sqe) begin
      irq_d = 1'b1; // [R3]
    end
    if (tx_event_irq_enable_q[mtrc_pkg::TX_SUCCESS_IRQ_EN] && ev_tx_ok) begin
      irq_d = 1'b1; // [R4]
    end
    if (tx_event_irq_enable_q[mtrc_pkg::LATE_COLLISION_IRQ_EN] && ev_late_collision)
    begin
      irq_d = 1'b1; // [R5]
    end
    if (tx_event_irq_enable_q[mtrc_pkg::BABBLE_IRQ_EN] && ev_babble) begin
      irq_d = 1'b1; // [R6]
    end
    if (tx_event_irq_enable_q[mtrc_pkg::ANY_COLLISION_IRQ_EN] && ev_collision) begin
      irq_d = 1'b1; // [R7]
    end
    if (tx_event_irq_enable_q[mtrc_pkg::MAX_ATTEMPTS_IRQ_EN] && ev_collision &&
        start_q && (attempts_q + 5'h01 == mtrc_pkg::MAX_ATTEMPTS)) begin
      irq_d = 1'b1; // [R8]
    end
    if (buffer_irq_enable_q[mtrc_pkg::TX_SPACE_IRQ_EN] &&
        (state_q == mtrc_pkg::MTRC_WAIT_SPACE) && space_ok) begin
      irq_d = 1'b1; // [R9]
    end
    if (buffer_irq_enable_q[mtrc_pkg::TX_STARVE_IRQ_EN] && ev_underrun) begin
      irq_d = 1'b1; // [R10]
    end
    if (buffer_irq_enable_q[mtrc_pkg::COLLISION_COUNT_WRAP_IRQ_EN] && col_wrap) begin
      irq_d = 1'b1; // [R11]
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_event_irq_enable_q <= mtrc_pkg::REG_RESET;
      buffer_irq_enable_q <= mtrc_pkg::REG_RESET;
      line_control_q <= mtrc_pkg::REG_RESET;
      transmit_command_q <= mtrc_pkg::REG_RESET;
      pend_cmd_q <= mtrc_pkg::REG_RESET;
      req_len_q <= 11'h000;
      byte_cnt_q <= 11'h000;
      wire_len_q <= 11'h000;
      collision_counter_q <= 10'h000;
      attempts_q <= 5'h00;
      req_err_q <= 1'b0;
      ready_now_q <= 1'b0;
      start_q <= 1'b0;
      fcs_q <= 1'b0;
      stop_q <= 1'b0;
      discard_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= 16'h0000;
      state_q <= mtrc_pkg::MTRC_IDLE;
    end else begin
      tx_event_irq_enable_q <= tx_event_irq_enable_d;
      buffer_irq_enable_q <= buffer_irq_enable_d;
      line_control_q <= line_control_d;
      transmit_command_q <= transmit_command_d;
      pend_cmd_q <= pend_cmd_d;
      req_len_q <= req_len_d;
      byte_cnt_q <= byte_cnt_d;
      wire_len_q <= wire_len_d;
      collision_counter_q <= collision_counter_d;
      attempts_q <= attempts_d;
      req_err_q <= req_err_d;
      ready_now_q <= ready_now_d;
      start_q <= start_d;
      fcs_q <= fcs_d;
      stop_q <= stop_d;
      discard_q <= discard_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign tx_irq = irq_q;
  assign tx_start = start_q;
  assign tx_wire_len = wire_len_q;
  assign tx_fcs_append = fcs_q;
  assign tx_retry_stop = stop_q;
  assign tx_discard = discard_q;
  assign serial_tx_en = line_control_q[mtrc_pkg::SERIAL_TX_EN];
  assign port_select = {line_control_q[mtrc_pkg::AUTO_PORT_SELECT],
                        line_control_q[mtrc_pkg::ATTACHMENT_PORT_ONLY]};
  assign alt_backoff = line_control_q[mtrc_pkg::ALT_BACKOFF_EN];
endmodule

// ===== common/mtrc_pkg.sv
// Constants for the transmit request and configuration block
package mtrc_pkg;
  // Register offsets (12-bit register address space)
  localparam logic [11:0] OFS_TX_EVENT_IRQ_ENABLE = 12'h106;
  localparam logic [11:0] OFS_BUFFER_IRQ_ENABLE = 12'h10A;
  localparam logic [11:0] OFS_LINE_CONTROL = 12'h112;
  localparam logic [11:0] OFS_COLLISION_COUNTER = 12'h132;
  localparam logic [11:0] OFS_BUS_STATUS = 12'h138;
  localparam logic [11:0] OFS_TRANSMIT_COMMAND = 12'h144;
  localparam logic [11:0] OFS_TRANSMIT_FRAME_LENGTH = 12'h146;
  // Transmit event interrupt enable bits
  localparam int CARRIER_LOSS_IRQ_EN = 6;
  localparam int SIGNAL_QUALITY_ERR_IRQ_EN = 7;
  localparam int TX_SUCCESS_IRQ_EN = 8;
  localparam int LATE_COLLISION_IRQ_EN = 9;
  localparam int BABBLE_IRQ_EN = 10;
  localparam int ANY_COLLISION_IRQ_EN = 11;
  localparam int MAX_ATTEMPTS_IRQ_EN = 15;
  // Buffer interrupt enable bits
  localparam int TX_SPACE_IRQ_EN = 8;
  localparam int TX_STARVE_IRQ_EN = 9;
  localparam int COLLISION_COUNT_WRAP_IRQ_EN = 12;
  // Line control bits
  localparam int SERIAL_TX_EN = 7;
  localparam int ATTACHMENT_PORT_ONLY = 8;
  localparam int AUTO_PORT_SELECT = 9;
  localparam int ALT_BACKOFF_EN = 11;
  // Transmit command fields
  localparam int START_SEL_LSB = 6;
  localparam int FORCE_DISCARD = 8;
  localparam int SINGLE_ATTEMPT = 9;
  localparam int FCS_SUPPRESS = 12;
  localparam int PAD_DISABLE = 13;
  // Bus status bits
  localparam int TX_REQUEST_ERROR = 7;
  localparam int TX_SPACE_READY_NOW = 8;
  // Writable masks and reset values
  localparam logic [15:0] TX_EVENT_IRQ_MASK = 16'h8FC0;
  localparam logic [15:0] BUFFER_IRQ_MASK = 16'h1300;
  localparam logic [15:0] LINE_CONTROL_MASK = 16'h2B80;
  localparam logic [15:0] TRANSMIT_COMMAND_MASK = 16'h33C0;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Start thresholds in bytes
  localparam logic [10:0] START_AFTER_5 = 11'd5;
  localparam logic [10:0] START_AFTER_381 = 11'd381;
  localparam logic [10:0] START_AFTER_1021 = 11'd1021;
  // Frame length limits in bytes and the attempt limit
  localparam logic [10:0] PAD_TARGET = 11'd60;
  localparam logic [10:0] FCS_BYTES = 11'd4;
  localparam logic [10:0] MIN_SENDABLE = 11'd3;
  localparam logic [10:0] MAX_FRAME = 11'd1514;
  localparam logic [4:0] MAX_ATTEMPTS = 5'd16;
  // Request sequence states
  typedef enum logic [2:0] {
    MTRC_IDLE, MTRC_CMD_DONE, MTRC_LEN_DONE, MTRC_WAIT_SPACE, MTRC_FILL
  } mtrc_req_e;
endpackage

// ===== verif/mtrc_checker.sv
// Concurrent checks on the ports of the transmit request block
`timescale 1ns/1ns
module mtrc_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic ev_sqe,
  input wire logic ev_tx_ok,
  input wire logic ev_late_collision,
  input wire logic ev_collision,
  input wire logic tx_irq,
  input wire logic tx_start,
  input wire logic [10:0] tx_wire_len,
  input wire logic tx_fcs_append,
  input wire logic tx_retry_stop,
  input wire logic tx_discard
);
  logic [15:0] ten_q, ten_d, cmd_q, cmd_d;
  logic [10:0] len_q, len_d;
  logic [10:0] exp_len;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Shadow copies of enables, command and length
  always_comb begin
    ten_d = ten_q;
    cmd_d = cmd_q;
    len_d = len_q;
    if (reg_wr && reg_addr == mtrc_pkg::OFS_TX_EVENT_IRQ_ENABLE) ten_d = reg_wdata;
    if (reg_wr && reg_addr == mtrc_pkg::OFS_TRANSMIT_COMMAND) cmd_d = reg_wdata;
    if (reg_wr && reg_addr == mtrc_pkg::OFS_TRANSMIT_FRAME_LENGTH) len_d = reg_wdata[10:0];
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ten_q <= 16'h0000;
      cmd_q <= 16'h0000;
      len_q <= 11'h000;
    end else begin
      ten_q <= ten_d;
      cmd_q <= cmd_d;
      len_q <= len_d;
    end
  end
  // Wire length the request should produce
  assign exp_len = cmd_q[12] ? len_q : ((len_q < 11'h03C) ? 11'h040 : len_q + 11'h004);
  sqe_irq_a: assert property (ev_sqe && ten_q[7] |=> tx_irq)
    else $error("sqe event gave no interrupt");
  ok_irq_a: assert property (ev_tx_ok && ten_q[8] |=> tx_irq)
    else $error("success event gave no interrupt");
  late_irq_a: assert property (ev_late_collision && ten_q[9] |=> tx_irq)
    else $error("late collision gave no interrupt");
  any_coll_irq_a: assert property (ev_collision && ten_q[11] |=> tx_irq)
    else $error("collision gave no interrupt");
  cmd_readback_a: assert property (reg_rd && reg_addr == mtrc_pkg::OFS_TRANSMIT_COMMAND
    |=> reg_rdata == (cmd_q & mtrc_pkg::TRANSMIT_COMMAND_MASK))
    else $error("command readback differs");
  discard_pulse_a: assert property (reg_wr && reg_addr == mtrc_pkg::OFS_TRANSMIT_COMMAND
    && reg_wdata[8] |=> tx_discard)
    else $error("force bit gave no discard");
  single_try_a: assert property (ev_collision && tx_start && cmd_q[9] |=> tx_retry_stop)
    else $error("single attempt not stopped");
  start_shape_a: assert property ($rose(tx_start) |->
    tx_fcs_append == !cmd_q[12] && tx_wire_len == exp_len)
    else $error("wire length or check value wrong at start");
  cover property ($rose(tx_start));
  cover property (tx_retry_stop);
  cover property (tx_discard);
endmodule

// ===== verif/mtrc_host.sv
// Host processor model driving the register port
`timescale 1ns/1ns
module mtrc_host (
  input wire logic mclk,
  output logic [11:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  logic [15:0] lc = 16'h0000;
  initial begin
    reg_addr = 12'h000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write, bus scrambled once released
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
  // Full transmit request in its fixed order
  task automatic req(input logic [15:0] c, input logic [15:0] n, output logic [15:0] d);
    wr(mtrc_pkg::OFS_TRANSMIT_COMMAND, c);
    wr(mtrc_pkg::OFS_TRANSMIT_FRAME_LENGTH, n);
    rd(mtrc_pkg::OFS_BUS_STATUS, d);
  endtask
  // Port bits change only with serial transmit held off
  task automatic line(input logic [15:0] v);
    wr(mtrc_pkg::OFS_LINE_CONTROL, lc & 16'hFF7F);
    wr(mtrc_pkg::OFS_LINE_CONTROL, v & 16'hFF7F);
    wr(mtrc_pkg::OFS_LINE_CONTROL, v);
    lc = v;
  endtask
endmodule

// ===== verif/mtrc_core_tb.sv
// Self-checking bench for the transmit request block
`timescale 1ns/1ns
module mtrc_core_tb;
  logic mclk = 1'b0, arst_n = 1'b0, data_wr = 1'b0, aui_active = 1'b0;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d, w, ten, ben;
  logic reg_wr, reg_rd, tx_irq, tx_start, tx_fcs_append, tx_retry_stop, tx_discard;
  logic serial_tx_en, alt_backoff, seen;
  logic [1:0] port_select;
  logic [10:0] tx_wire_len, buf_free_bytes = 11'h7FF;
  logic [6:0] ev = 7'h00;
  logic [11:0] ofs [6] = '{12'h200, 12'h146, 12'h106, 12'h10A, 12'h112, 12'h144};
  logic [15:0] msk [6] = '{16'h0000, 16'h0000, 16'h8FC0, 16'h1300, 16'h2B80, 16'h33C0};
  logic [15:0] fcmd [6] = '{16'h0000, 16'h1040, 16'h2080, 16'h30C0, 16'h1000, 16'h0000};
  int flen [6] = '{10, 400, 1100, 40, 59, 0};
  int bad_count = 0, checks = 0, cyc = 0, coll = 0, att = 0;
  bit run = 0;
  mtrc_host mtrc_host_inst (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  mtrc_core mtrc_core_inst (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .data_wr, .buf_free_bytes, .aui_active, .ev_carrier_loss(ev[0]),
    .ev_sqe(ev[1]), .ev_tx_ok(ev[2]), .ev_late_collision(ev[3]), .ev_babble(ev[4]),
    .ev_collision(ev[5]), .ev_underrun(ev[6]), .tx_irq, .tx_start, .tx_wire_len,
    .tx_fcs_append, .tx_retry_stop, .tx_discard, .serial_tx_en, .port_select, .alt_backoff);
  always #2 mclk = ~mclk;
  // Cut a hung run short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic set_en(input logic [15:0] t, input logic [15:0] b);
    ten = t & 16'h8FC0;
    ben = b & 16'h1300;
    mtrc_host_inst.wr(12'h106, t);
    mtrc_host_inst.wr(12'h10A, b);
  endtask
  // One event pulse, interrupt predicted from the enable model
  task automatic pulse(input int i);
    logic e;
    e = (i == 6) ? ben[9] : ten[i + 6];
    if (i == 5) begin
      coll++;
      if (coll % 1024 == 0) e = e | ben[12];
      if (run) att++;
      if (att == 16) e = e | ten[15];
    end
    @(posedge mclk);
    // Port state is read once the caller's update has landed
    if (i == 0) e = e & aui_active;
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev[i] <= 1'b0;
    #1;
    chk_bit(tx_irq, e);
  endtask
  task automatic send(input int n);
    if (n > 0) begin
      @(posedge mclk);
      data_wr <= 1'b1;
      repeat (n) @(posedge mclk);
      data_wr <= 1'b0;
    end
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // Request, fill up to the start threshold and check the start edge
  task automatic frame(input logic [15:0] c, input int n);
    int thr, x;
    thr = (c[7:6] == 2'h0) ? 5 : (c[7:6] == 2'h1) ? 381 : (c[7:6] == 2'h2) ? 1021 : n;
    if (thr > n) thr = n;
    x = c[12] ? n : ((n < 60) ? 60 : n) + 4;
    mtrc_host_inst.req(c, 16'(n), d);
    mtrc_host_inst.rd(12'h138, d);
    chk_reg(d & 16'h0180, 16'h0100);
    chk_reg({5'h00, tx_wire_len}, 16'(x));
    chk_bit(tx_fcs_append, !c[12]);
    send(thr - 1);
    chk_bit(tx_start, 1'b0);
    send(1);
    chk_bit(tx_start, 1'b1);
    run = 1;
    att = 0;
  endtask
  task automatic stopped();
    run = 0;
    send(0);
    chk_bit(tx_start, 1'b0);
  endtask
  initial begin
    void'($urandom(54296));
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (ofs[k]) begin
      mtrc_host_inst.rd(ofs[k], d);
      chk_reg(d, 16'h0000);
      w = 16'($urandom);
      mtrc_host_inst.wr(ofs[k], w);
      mtrc_host_inst.rd(ofs[k], d);
      chk_reg(d, w & msk[k]);
    end
    w = 16'($urandom) | 16'h0080;
    mtrc_host_inst.line(w);
    #1;
    chk_reg({12'h000, alt_backoff, port_select, serial_tx_en}, {12'h000, w[11], w[9:7]});
    for (int p = 0; p < 2; p++) begin
      w = 16'($urandom);
      set_en(p ? ~w : w, p ? w : ~w);
      aui_active <= 1'b1;
      pulse(0);
      aui_active <= 1'b0;
      for (int i = 0; i < 7; i++) pulse(i);
    end
    set_en(16'h8100, 16'h0000);
    flen[5] = 60 + int'($urandom % 400);
    foreach (fcmd[k]) begin
      frame(fcmd[k], flen[k]);
      pulse(2);
      stopped();
    end
    frame(16'h0200, 20);
    pulse(5);
    chk_bit(tx_retry_stop, 1'b1);
    stopped();
    frame(16'h0000, 20);
    for (int k = 1; k <= 16; k++) begin
      pulse(5);
      chk_bit(tx_retry_stop, k == 16);
    end
    stopped();
    frame(16'h0000, 100);
    mtrc_host_inst.wr(12'h144, 16'h0100);
    #1;
    chk_bit(tx_discard, 1'b1);
    stopped();
    mtrc_host_inst.req(16'h0000, 16'h0000, d);
    chk_reg(d & 16'h0180, 16'h0080);
    mtrc_host_inst.req(16'h0000, 16'd1515, d);
    chk_reg(d & 16'h0180, 16'h0080);
    mtrc_host_inst.req(16'h3000, 16'h0002, d);
    chk_reg(d & 16'h0180, 16'h0080);
    set_en(16'h0000, 16'h0100);
    buf_free_bytes <= 11'h032;
    mtrc_host_inst.req(16'h0000, 16'd100, d);
    mtrc_host_inst.rd(12'h138, d);
    chk_reg(d & 16'h0100, 16'h0000);
    seen = 1'b0;
    buf_free_bytes <= 11'h7FF;
    repeat (10) @(posedge mclk) seen = seen | tx_irq;
    chk_bit(seen, 1'b1);
    mtrc_host_inst.rd(12'h138, d);
    chk_reg(d & 16'h0100, 16'h0100);
    mtrc_host_inst.wr(12'h144, 16'h0100);
    set_en(16'h0000, 16'h1000);
    repeat (1024 - coll % 1024) pulse(5);
    mtrc_host_inst.rd(12'h132, d);
    chk_reg(d, 16'h0000);
    conclude();
  end
endmodule
bind mtrc_core mtrc_checker mtrc_checker_inst (.mclk(mclk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ev_sqe(ev_sqe), .ev_tx_ok(ev_tx_ok),
  .ev_late_collision(ev_late_collision), .ev_collision(ev_collision), .tx_irq(tx_irq),
  .tx_start(tx_start), .tx_wire_len(tx_wire_len), .tx_fcs_append(tx_fcs_append),
  .tx_retry_stop(tx_retry_stop), .tx_discard(tx_discard));
